// file: shared/e3ptm_pkg.sv
// Constants, field layouts and carrier types of the E3 path termination and mapper
package e3ptm_pkg;
    // ==========================================================
    // Frame layout
    localparam logic [10:0] FRAME_LAST = 11'h5FF;
    localparam logic [10:0] SET2_START = 11'h180;
    localparam logic [10:0] SET3_START = 11'h300;
    localparam logic [10:0] SET4_START = 11'h480;
    localparam logic [10:0] OH_BITS = 11'h00C;
    localparam logic [10:0] CTL_BITS = 11'h004;
    localparam logic [10:0] JUS_END = 11'h008;
    localparam logic [9:0] FAS_WORD = 10'h3D0;
    localparam logic [10:0] FAS_LAST_POS = 11'h009;
    localparam logic [10:0] RDI_POS = 11'h00A;
    localparam logic [10:0] USER_POS = 11'h00B;
    localparam logic [2:0] RDI_FILTER_LAST = 3'h4;
    // ==========================================================
    // Elastic store
    localparam int unsigned ES_DEPTH = 16;
    localparam logic [4:0] JUST_THRESH = 5'h08;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned RDI_LIMIT_US = 800;
    localparam int unsigned RDI_LIMIT_CYC = RDI_LIMIT_US * CLK_MHZ;
    // ==========================================================
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // ==========================================================
    // Carrier types
    typedef enum logic [1:0] {
        SLOT_OH = 2'b00,
        SLOT_PAY = 2'b01,
        SLOT_CTL = 2'b10,
        SLOT_JUS = 2'b11
    } e3ptm_kind_type;
    typedef struct packed {
        e3ptm_kind_type kind;
        logic [1:0] trib;
    } e3ptm_slot_type;
    typedef struct packed {
        logic active;
        logic mon;
        logic rdi_rep;
        logic ssf_rep;
    } e3ptm_ctrl_type;
    typedef struct packed {
        logic data;
        logic clk;
        logic fs;
    } e3ptm_line_type;
    typedef struct packed {
        e3ptm_line_type rx;
        logic server_fail;
        logic agg_clk;
        logic agg_fs;
        logic ap_data;
        logic trib_data;
        logic trib_clk;
        logic rdi_req;
        logic user_bit;
        logic sec_tick;
    } e3ptm_pins_type;
endpackage

// file: logic/e3ptm_top.sv
// E3 path termination source/sink with one tributary mapper and Wishbone registers
// Notes on behaviour
// - Frame is 1536 bits, 12 overhead
// - Overhead fills first 12 bits after frame start
// - Source writes alignment word 1111010000
// - Remote defect bit follows request within 800us
// - Alignment mismatch counts errored block per second
// - Sink extracts remote defect bit
// - Server fail drives trail fail and request
// - Remote cause gated by monitoring and enable
// - Server cause gated by monitoring and enable
// - Remote defect flags far-end defect second
// - One tributary mapped into selected slot
// - Elastic store written by tributary clock
// - Justification skips one read, opportunity empty
// - Control group placed in control positions
// - Slot index parameter one to four
// - Access point driven only while active
// - Store depth tolerates rate offset steps
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module e3ptm_top #(
    parameter logic [2:0] TRIB_SLOT = 3'h1,
    parameter int unsigned RDI_LIMIT_CYC = e3ptm_pkg::RDI_LIMIT_CYC
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire e3ptm_pkg::e3ptm_line_type CI_RX_I,
    input wire logic SERVER_FAIL_IN_I,
    input wire logic ONE_SECOND_TICK_I,
    input wire logic AGGREGATE_TIMING_CLOCK_I,
    input wire logic AGGREGATE_FRAME_START_I,
    input wire logic AP_DATA_I,
    input wire logic TRIBUTARY_DATA_I,
    input wire logic TRIBUTARY_CLOCK_I,
    input wire logic REMOTE_DEFECT_REQUEST_I,
    input wire logic OPERATOR_USER_BIT_I,
    output logic [e3ptm_pkg::ES_DEPTH-1:0] UNUSED_NONE_O,
    output e3ptm_pkg::e3ptm_line_type CI_TX_O,
    output logic TRAIL_FAIL_ACTION_O,
    output logic REMOTE_DEFECT_REQUEST_O,
    output logic REMOTE_DEFECT_CAUSE_O,
    output logic SERVER_FAIL_CAUSE_O,
    output logic FAR_END_DEFECT_SECOND_O,
    output logic NEAR_END_DEFECT_SECOND_O,
    output logic NEAR_END_ERRORED_BLOCK_O,
    output logic [15:0] NEAR_END_ERROR_BLOCK_COUNT_O,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O
);
    import e3ptm_pkg::*;
    // ==========================================================
    // Frame position decode
    function automatic e3ptm_slot_type slot_decode(input logic [10:0] pos);
        logic [10:0] offs;
        logic [1:0] set;
        e3ptm_slot_type s;
        offs = pos;
        set = 2'h0;
        if (pos >= SET4_START) begin
            offs = pos - SET4_START;
            set = 2'h3;
        end else if (pos >= SET3_START) begin
            offs = pos - SET3_START;
            set = 2'h2;
        end else if (pos >= SET2_START) begin
            offs = pos - SET2_START;
            set = 2'h1;
        end
        s.trib = offs[1:0];
        if (set == 2'h0 && offs < OH_BITS) begin
            s.kind = SLOT_OH;
        end else if (set != 2'h0 && offs < CTL_BITS) begin
            s.kind = SLOT_CTL;
        end else if (set == 2'h3 && offs < JUS_END) begin
            s.kind = SLOT_JUS;
        end else begin
            s.kind = SLOT_PAY;
        end
        return s;
    endfunction
    function automatic logic [10:0] pos_step(input logic fs, input logic [10:0] pos);
        return (fs || pos == FRAME_LAST) ? 11'h000 : pos + 11'h001;
    endfunction
    // ==========================================================
    // Pin synchronisers, all inputs except the Wishbone port cross from outside
    e3ptm_pins_type async_in, sync1_q, sync2_q, prev_q;
    assign async_in = '{rx: CI_RX_I, server_fail: SERVER_FAIL_IN_I, agg_clk: AGGREGATE_TIMING_CLOCK_I,
                        agg_fs: AGGREGATE_FRAME_START_I, ap_data: AP_DATA_I, trib_data: TRIBUTARY_DATA_I,
                        trib_clk: TRIBUTARY_CLOCK_I, rdi_req: REMOTE_DEFECT_REQUEST_I,
                        user_bit: OPERATOR_USER_BIT_I, sec_tick: ONE_SECOND_TICK_I};
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end
    // Clocks and data share the same two-stage delay, so sampling stays aligned
    logic agg_rise, trib_rise, rx_rise, sec_rise;
    assign agg_rise = sync2_q.agg_clk & ~prev_q.agg_clk;
    assign trib_rise = sync2_q.trib_clk & ~prev_q.trib_clk;
    assign rx_rise = sync2_q.rx.clk & ~prev_q.rx.clk;
    assign sec_rise = sync2_q.sec_tick & ~prev_q.sec_tick;
    // ==========================================================
    // Registers seen by software
    e3ptm_ctrl_type ctrl_q, ctrl_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    // ==========================================================
    // Source: elastic store, mapper and overhead insertion
    logic [ES_DEPTH-1:0] mem_q, mem_d;
    logic [4:0] wr_q, wr_d, rd_q, rd_d, fill;
    logic [10:0] tx_pos_q, tx_pos_d, tx_pos_n;
    logic tx_data_q, tx_data_d, tx_fs_q, tx_fs_d, tx_clk_q;
    logic just_q, just_d, mine;
    e3ptm_slot_type tx_slot;
    assign fill = wr_q - rd_q;
    assign tx_pos_n = pos_step(sync2_q.agg_fs, tx_pos_q);
    assign tx_slot = slot_decode(tx_pos_n);
    assign mine = ctrl_q.active && tx_slot.kind != SLOT_OH
                  && tx_slot.trib == 2'(TRIB_SLOT - 3'h1);
    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = ctrl_q.active ? rd_q : wr_q - JUST_THRESH; // Idle store stays half full, no wrap
        tx_pos_d = tx_pos_q;
        tx_data_d = tx_data_q;
        tx_fs_d = tx_fs_q;
        just_d = just_q;
        if (trib_rise) begin
            mem_d[wr_q[3:0]] = sync2_q.trib_data;
            wr_d = wr_q + 5'h01;
        end
        if (agg_rise) begin
            tx_pos_d = tx_pos_n;
            tx_fs_d = (tx_pos_n == 11'h000);
            if (tx_pos_n == 11'h000) begin
                // Justify when the store runs low; depth covers the offset range
                just_d = (fill < JUST_THRESH);
            end
            if (tx_slot.kind == SLOT_OH) begin
                if (tx_pos_n <= FAS_LAST_POS) begin
                    tx_data_d = FAS_WORD[4'h9 - tx_pos_n[3:0]];
                end else if (tx_pos_n == RDI_POS) begin
                    tx_data_d = sync2_q.rdi_req;
                end else begin
                    tx_data_d = sync2_q.user_bit;
                end
            end else if (!mine) begin
                tx_data_d = sync2_q.ap_data;
            end else if (tx_slot.kind == SLOT_CTL) begin
                tx_data_d = just_q;
            end else if (tx_slot.kind == SLOT_JUS && just_q) begin
                tx_data_d = 1'b0;
            end else begin
                tx_data_d = mem_q[rd_q[3:0]];
                rd_d = rd_q + 5'h01;
            end
        end
    end
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mem_q <= '0;
            wr_q <= JUST_THRESH;
            rd_q <= 5'h00;
            tx_pos_q <= 11'h000;
            tx_data_q <= 1'b0;
            tx_fs_q <= 1'b0;
            tx_clk_q <= 1'b0;
            just_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            tx_pos_q <= tx_pos_d;
            tx_data_q <= tx_data_d;
            tx_fs_q <= tx_fs_d;
            tx_clk_q <= sync2_q.agg_clk;
            just_q <= just_d;
        end
    end
    assign CI_TX_O = '{data: tx_data_q, clk: tx_clk_q, fs: tx_fs_q};
    assign UNUSED_NONE_O = '0;
    // ==========================================================
    // Sink: alignment check, defect filter, correlation, per-second counts
    logic [10:0] rx_pos_q, rx_pos_d, rx_pos_n;
    logic fas_err_q, fas_err_d, blk_err_q, blk_err_d, fas_bad;
    logic rdi_det_q, rdi_det_d;
    logic [2:0] rdi_cnt_q, rdi_cnt_d;
    logic [15:0] ebc_acc_q, ebc_acc_d, ebc_q, ebc_d;
    logic fds_acc_q, fds_acc_d, fds_q, fds_d, nds_acc_q, nds_acc_d, nds_q, nds_d;
    logic tsf_q, rdi_cause_q, rdi_cause_d, ssf_cause_q, ssf_cause_d;
    assign rx_pos_n = pos_step(sync2_q.rx.fs, rx_pos_q);
    assign fas_bad = (rx_pos_n <= FAS_LAST_POS) && (sync2_q.rx.data != FAS_WORD[4'h9 - rx_pos_n[3:0]]);
    always_comb begin
        rx_pos_d = rx_pos_q;
        fas_err_d = fas_err_q;
        blk_err_d = 1'b0;
        rdi_det_d = rdi_det_q;
        rdi_cnt_d = rdi_cnt_q;
        if (rx_rise) begin
            rx_pos_d = rx_pos_n;
            fas_err_d = ((rx_pos_n == 11'h000) ? 1'b0 : fas_err_q) | fas_bad;
            blk_err_d = (rx_pos_n == FAS_LAST_POS) && fas_err_d;
            if (rx_pos_n == RDI_POS) begin
                // Five equal frames in a row flip the defect state
                if (sync2_q.rx.data == rdi_det_q) begin
                    rdi_cnt_d = 3'h0;
                end else if (rdi_cnt_q == RDI_FILTER_LAST) begin
                    rdi_cnt_d = 3'h0;
                    rdi_det_d = ~rdi_det_q;
                end else begin
                    rdi_cnt_d = rdi_cnt_q + 3'h1;
                end
            end
        end
        // A block or defect in the tick cycle opens the new second
        ebc_acc_d = sec_rise ? 16'(blk_err_q) : ebc_acc_q + 16'(blk_err_q);
        ebc_d = sec_rise ? ebc_acc_q : ebc_q;
        fds_acc_d = sec_rise ? rdi_det_q : (fds_acc_q | rdi_det_q);
        fds_d = sec_rise ? fds_acc_q : fds_q;
        nds_acc_d = sec_rise ? sync2_q.server_fail : (nds_acc_q | sync2_q.server_fail);
        nds_d = sec_rise ? nds_acc_q : nds_q;
        rdi_cause_d = rdi_det_q && ctrl_q.mon && ctrl_q.rdi_rep;
        ssf_cause_d = sync2_q.server_fail && ctrl_q.mon && ctrl_q.ssf_rep;
    end
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rx_pos_q <= 11'h000;
            fas_err_q <= 1'b0;
            blk_err_q <= 1'b0;
            rdi_det_q <= 1'b0;
            rdi_cnt_q <= 3'h0;
            ebc_acc_q <= 16'h0000;
            ebc_q <= 16'h0000;
            fds_acc_q <= 1'b0;
            fds_q <= 1'b0;
            nds_acc_q <= 1'b0;
            nds_q <= 1'b0;
            tsf_q <= 1'b0;
            rdi_cause_q <= 1'b0;
            ssf_cause_q <= 1'b0;
        end else begin
            rx_pos_q <= rx_pos_d;
            fas_err_q <= fas_err_d;
            blk_err_q <= blk_err_d;
            rdi_det_q <= rdi_det_d;
            rdi_cnt_q <= rdi_cnt_d;
            ebc_acc_q <= ebc_acc_d;
            ebc_q <= ebc_d;
            fds_acc_q <= fds_acc_d;
            fds_q <= fds_d;
            nds_acc_q <= nds_acc_d;
            nds_q <= nds_d;
            tsf_q <= sync2_q.server_fail;
            rdi_cause_q <= rdi_cause_d;
            ssf_cause_q <= ssf_cause_d;
        end
    end
    assign TRAIL_FAIL_ACTION_O = tsf_q;
    assign REMOTE_DEFECT_REQUEST_O = tsf_q;
    assign REMOTE_DEFECT_CAUSE_O = rdi_cause_q;
    assign SERVER_FAIL_CAUSE_O = ssf_cause_q;
    assign FAR_END_DEFECT_SECOND_O = fds_q;
    assign NEAR_END_DEFECT_SECOND_O = nds_q;
    assign NEAR_END_ERRORED_BLOCK_O = blk_err_q;
    assign NEAR_END_ERROR_BLOCK_COUNT_O = ebc_q;
    // ==========================================================
    // Wishbone classic slave, one wait state, unmapped reads give zero
    always_comb begin
        ctrl_d = ctrl_q;
        ack_d = WB_CYC_I && WB_STB_I && !ack_q;
        dat_d = dat_q;
        if (ack_d && !WB_WE_I) begin
            case (WB_ADR_I)
                REG_CTRL: dat_d = {28'h000_0000, ctrl_q};
                REG_STATUS: dat_d = {25'h000_0000, nds_q, fds_q, rdi_det_q, just_q, ssf_cause_q, rdi_cause_q, tsf_q};
                REG_COUNT: dat_d = {16'h0000, ebc_q};
                default: dat_d = 32'h0000_0000;
            endcase
        end
        if (ack_q && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == REG_CTRL) begin
            ctrl_d = WB_DAT_I[3:0];
        end
    end
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_q <= CTRL_RESET;
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;
    // ==========================================================
    // Checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_frame_start;
        agg_rise && sync2_q.agg_fs |=> tx_pos_q == 11'h000 && tx_fs_q;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame start not at position zero");
    property p_fas_insert;
        agg_rise && tx_pos_n <= FAS_LAST_POS |=> tx_data_q == FAS_WORD[4'h9 - tx_pos_q[3:0]];
    endproperty
    a_fas_insert: assert property (p_fas_insert) else $error("alignment bit wrong");
    property p_rdi_insert;
        agg_rise && tx_pos_n == RDI_POS |=> tx_data_q == $past(sync2_q.rdi_req);
    endproperty
    a_rdi_insert: assert property (p_rdi_insert) else $error("remote defect bit wrong");
    property p_block_err;
        rx_rise && rx_pos_n == FAS_LAST_POS && fas_bad |=> blk_err_q ##1 !blk_err_q;
    endproperty
    a_block_err: assert property (p_block_err) else $error("errored block missed");
    property p_ssf;
        sync2_q.server_fail |=> TRAIL_FAIL_ACTION_O && REMOTE_DEFECT_REQUEST_O;
    endproperty
    a_ssf: assert property (p_ssf) else $error("server fail not followed");
    property p_rdi_cause;
        !ctrl_q.rdi_rep || !ctrl_q.mon |=> !rdi_cause_q;
    endproperty
    a_rdi_cause: assert property (p_rdi_cause) else $error("remote cause while gated");
    property p_ssf_cause;
        ssf_cause_q |-> $past(sync2_q.server_fail && ctrl_q.mon && ctrl_q.ssf_rep);
    endproperty
    a_ssf_cause: assert property (p_ssf_cause) else $error("server cause without cause");
    property p_fds;
        rdi_det_q ##1 sec_rise |=> fds_q;
    endproperty
    a_fds: assert property (p_fds) else $error("far-end second not flagged");
    property p_filter;
        $changed(rdi_det_q) |-> $past(rdi_cnt_q) == RDI_FILTER_LAST && $past(rx_rise);
    endproperty
    a_filter: assert property (p_filter) else $error("defect filter too short");
    property p_skip;
        agg_rise && mine && tx_slot.kind == SLOT_JUS && just_q |=> rd_q == $past(rd_q) && !tx_data_q;
    endproperty
    a_skip: assert property (p_skip) else $error("justification read not skipped");
    property p_ccc;
        agg_rise && mine && tx_slot.kind == SLOT_CTL |=> tx_data_q == $past(just_q);
    endproperty
    a_ccc: assert property (p_ccc) else $error("control bit wrong");
    property p_inactive;
        agg_rise && !ctrl_q.active && tx_slot.kind != SLOT_OH |=> tx_data_q == $past(sync2_q.ap_data);
    endproperty
    a_inactive: assert property (p_inactive) else $error("access point touched while inactive");
    c_wrap: cover property (agg_rise && tx_pos_q == FRAME_LAST);
    c_just: cover property (agg_rise && mine && tx_slot.kind == SLOT_JUS && just_q);
    c_rdi: cover property ($rose(rdi_det_q));
    c_ack: cover property (ack_q && WB_WE_I);
endmodule

// file: dv/e3ptm_line_partner.sv
// Far-end line transmitter that feeds framed bits to the trail sink
`timescale 1ns/1ps
module e3ptm_line_partner (
    input wire logic start_i,
    input wire logic bad_fas_i,
    input wire logic rdi_i,
    output e3ptm_pkg::e3ptm_line_type line_o,
    output int frames_o
);
    import e3ptm_pkg::*;
    int pos = 0;
    logic bad = 1'b0;
    logic rdi = 1'b0;
    logic clk_q = 1'b0;
    logic fs_q = 1'b0;
    logic dat_q = 1'b0;
    assign line_o = {dat_q, clk_q, fs_q};
    initial frames_o = 0;
    // ==========================================================
    // Line clock, held still until the bench starts the stream
    initial begin
        #13;
        forever begin
            #80;
            if (start_i)
                clk_q = ~clk_q;
        end
    end
    // ==========================================================
    // Bits change on the falling edge, away from the sampling edge
    always @(negedge clk_q) begin
        if (pos == 0) begin
            bad = bad_fas_i;
            rdi = rdi_i;
        end
        fs_q <= (pos == 0);
        if (pos < 10)
            dat_q <= FAS_WORD[9 - pos] ^ (bad && (pos == 3 || pos == 9));
        else if (pos == 10)
            dat_q <= rdi;
        else
            dat_q <= ~dat_q;
        pos = (pos == 1535) ? 0 : pos + 1;
        if (pos == 0)
            frames_o <= frames_o + 1;
    end
endmodule

// file: dv/e3ptm_top_bench.sv
// Self-checking bench for the E3 path termination and mapper
`timescale 1ns/1ps
module e3ptm_top_bench;
    import e3ptm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic srv = 1'b0;
    logic tick = 1'b0;
    logic tclk = 1'b0;
    logic tfs = 1'b0;
    logic ap = 1'b0;
    logic tdat = 1'b0;
    logic tck = 1'b0;
    logic rreq = 1'b0;
    logic ubit = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [15:0] unused;
    e3ptm_line_type tx;
    e3ptm_line_type rx;
    logic tfa, rdo, rdc, sfc, fds, nds, neb, ack;
    logic [15:0] nebc;
    logic [31:0] rdat;
    logic start = 1'b0;
    logic bad = 1'b0;
    logic rdi = 1'b0;
    int frames;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int eb_pulses = 0;
    int exp_eb = 0;
    int gpos = 0;
    int tpos = 0;
    logic [3:0] ctrl_m = 4'h0;
    logic [15:0] seed = 16'h0045;
    logic [1535:0] ap_pat;
    logic tx_sync = 1'b0;
    logic act_fs = 1'b0;
    logic [4:0] req_hist = 5'h00;
    logic [2:0] cbits = 3'h0;
    logic [31:0] r;

    e3ptm_top e3ptm_top_inst (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CI_RX_I(rx), .SERVER_FAIL_IN_I(srv),
        .ONE_SECOND_TICK_I(tick), .AGGREGATE_TIMING_CLOCK_I(tclk), .AGGREGATE_FRAME_START_I(tfs),
        .AP_DATA_I(ap), .TRIBUTARY_DATA_I(tdat), .TRIBUTARY_CLOCK_I(tck), .REMOTE_DEFECT_REQUEST_I(rreq),
        .OPERATOR_USER_BIT_I(ubit), .UNUSED_NONE_O(unused), .CI_TX_O(tx), .TRAIL_FAIL_ACTION_O(tfa),
        .REMOTE_DEFECT_REQUEST_O(rdo), .REMOTE_DEFECT_CAUSE_O(rdc), .SERVER_FAIL_CAUSE_O(sfc),
        .FAR_END_DEFECT_SECOND_O(fds), .NEAR_END_DEFECT_SECOND_O(nds), .NEAR_END_ERRORED_BLOCK_O(neb),
        .NEAR_END_ERROR_BLOCK_COUNT_O(nebc), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
    e3ptm_line_partner e3ptm_line_partner_inst (.start_i(start), .bad_fas_i(bad), .rdi_i(rdi),
        .line_o(rx), .frames_o(frames));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================================
    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h1;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        q = rdat;
        if (w && a == REG_CTRL)
            ctrl_m = d[3:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic pulse_tick();
        tick <= 1'b1;
        repeat (4) @(posedge clk);
        tick <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic wait_frames(input int n);
        while (frames < n)
            @(posedge clk);
    endtask
    // ==========================================================
    // Clocks: link clocks free of the system clock phase
    always #10 clk = ~clk;
    initial begin
        #7;
        forever #80 tclk = ~tclk;
    end
    initial begin
        #3;
        forever #326 tck = ~tck;
    end
    always @(negedge tclk) begin
        tfs <= (gpos == 0);
        ap <= ap_pat[gpos]; // Traffic of the other, inactive sources on the shared point
        gpos <= (gpos == 1535) ? 0 : gpos + 1;
    end
    always @(negedge tck) begin
        seed = lfsr(seed);
        tdat <= seed[0];
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (neb === 1'b1)
            eb_pulses <= eb_pulses + 1;
        if (cycles == 80000) begin
            n_errors = n_errors + 1;
            stop_test();
        end
    end
    // ==========================================================
    // Transmit frame model, sampled on the falling line clock
    always @(negedge tx.clk) begin
        if (tx.fs === 1'b1) begin
            if (tx_sync)
                chk(tpos, 1535);
            tx_sync = 1'b1;
            tpos = 0;
            act_fs = ctrl_m[3];
            req_hist = {req_hist[3:0], rreq};
        end else
            tpos = tpos + 1;
        if (tx_sync) begin
            if (tpos < 10)
                chk(tx.data, FAS_WORD[9 - tpos]);
            if (tpos == 10 && req_hist[0] == rreq)
                chk(tx.data, rreq);
            if (tpos == 11)
                chk(tx.data, ubit);
            if (tpos >= 12 && (!act_fs || tpos % 4 != 0) && act_fs == ctrl_m[3])
                chk(tx.data, ap_pat[tpos]);
            if (act_fs && tpos % 384 == 0 && tpos > 0)
                cbits = {cbits[1:0], tx.data};
            if (act_fs && tpos == 1156) begin
                chk(32'(cbits == 3'h7 || cbits == 3'h0), 1);
                if (cbits == 3'h7)
                    chk(tx.data, 0);
            end
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        for (int i = 0; i < 1536; i++) begin
            seed = lfsr(seed);
            ap_pat[i] = seed[0];
        end
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b1, REG_CTRL, 32'h0000_0007, r);
        wb(1'b0, REG_CTRL, 32'h0000_0000, r);
        chk(r, 32'h0000_0007);
        wb(1'b0, 8'h0C, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        chk(unused, 32'h0000_0000);
        srv <= 1'b1;
        repeat (8) @(posedge clk);
        chk({tfa, rdo, sfc}, 3'h7);
        pulse_tick();
        chk(nds, 1);
        wb(1'b1, REG_CTRL, 32'h0000_0006, r);
        repeat (4) @(posedge clk);
        chk(sfc, 0);
        srv <= 1'b0;
        repeat (8) @(posedge clk);
        chk({tfa, rdo}, 2'h0);
        wb(1'b1, REG_CTRL, 32'h0000_0007, r);
        start <= 1'b1;
        wait_frames(1);
        bad <= 1'b1;
        rdi <= 1'b1;
        rreq <= 1'b1;
        exp_eb = exp_eb + 1;
        wait_frames(2);
        bad <= 1'b0;
        wb(1'b1, REG_CTRL, 32'h0000_000F, r);
        chk(eb_pulses, exp_eb);
        wait_frames(5);
        chk(rdc, 0);
        wait_frames(6);
        repeat (5) @(posedge clk);
        chk(rdc, 1);
        pulse_tick();
        chk(fds, 1);
        chk(nebc, exp_eb);
        wb(1'b0, REG_COUNT, 32'h0000_0000, r);
        chk(r, exp_eb);
        wb(1'b1, REG_CTRL, 32'h0000_000D, r);
        repeat (4) @(posedge clk);
        chk(rdc, 0);
        stop_test();
    end
endmodule
